/* File: logic/aft_pulse_timer.v */
// interrupt timing: 2 ms pulse in 4 ms period, or one 2 ms shot
`timescale 1ns/1ps
`include "aft_defines.vh"
module aft_pulse_timer #(
   parameter PULSE_CYCLES  = `AFT_PULSE_MS * `AFT_CLK_KHZ,
   parameter PERIOD_CYCLES = `AFT_PERIOD_MS * `AFT_CLK_KHZ,
   parameter CW            = 19
) (
   input  wire mclk,
   input  wire reset_n,
   input  wire periodic,
   input  wire shot,
   output reg  active
);
   reg [CW-1:0] count;
   reg          running;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count   <= {CW{1'b0}};
         running <= 1'b0;
         active  <= 1'b0;
      end else if (periodic) begin
         running <= 1'b0;
         if (count >= PERIOD_CYCLES[CW-1:0] - 1'b1) begin
            count <= {CW{1'b0}};
         end else begin
            count <= count + 1'b1;
         end
         active <= (count < PULSE_CYCLES[CW-1:0]);
      end else if (shot && !running) begin
         running <= 1'b1;
         count   <= {CW{1'b0}};
         active  <= 1'b1;
      end else if (running) begin
         if (count >= PULSE_CYCLES[CW-1:0] - 1'b1) begin
            running <= 1'b0;
            active  <= 1'b0;
            count   <= {CW{1'b0}};
         end else begin
            count <= count + 1'b1;
         end
      end else begin
         count  <= {CW{1'b0}};
         active <= 1'b0;
      end
   end
endmodule

/* File: logic/aft_regs.v */
// interrupt, fault power-down, overload mute and power tune registers
`timescale 1ns/1ps
`include "aft_defines.vh"
module aft_regs #(
   parameter NFLAG         = 8,
   parameter CLK_KHZ       = `AFT_CLK_KHZ,
   parameter PULSE_CYCLES  = `AFT_PULSE_MS * CLK_KHZ,
   parameter PERIOD_CYCLES = `AFT_PERIOD_MS * CLK_KHZ,
   parameter CW            = 19
) (
   input  wire             mclk,
   input  wire             reset_n,
   input  wire             regWrite,
   input  wire             regRead,
   input  wire [7:0]       regAddr,
   input  wire [7:0]       regWdata,
   output reg  [7:0]       regRdata,
   input  wire [13:0]      ratioValue,
   input  wire             ratioDone,
   input  wire [NFLAG-1:0] liveFlag,
   input  wire [NFLAG-1:0] flagMask,
   input  wire             latchRead,
   output reg  [NFLAG-1:0] latchedView,
   input  wire [NFLAG-1:0] faultFlag,
   input  wire             ch1Overload,
   input  wire             ch2Overload,
   output reg              irqOut,
   output reg              channelPowerDown,
   output reg              ch1Mute,
   output reg              ch2Mute,
   output reg              modulatorClockHalve,
   output reg              combFilterOrder,
   output reg              firStageSkip,
   output reg              elementMatchingRateDouble,
   output reg              lowPowerFilterSel,
   output reg  [1:0]       ch1InputSource,
   output reg  [1:0]       ch1Coupling,
   output reg              ch1FullScale,
   output reg              ch1Bandwidth
);
   reg  [`AFT_RATIO_HIGH_W-1:0] ratioHigh;
   reg  [`AFT_RATIO_LOW_W-1:0]  ratioLow;
   reg  [7:0]       intCfg;
   reg  [7:0]       muteCfg;
   reg  [7:0]       tuneCfg;
   reg  [7:0]       ch1Cfg;
   reg  [NFLAG-1:0] latched;
   reg  [NFLAG-1:0] prevLive;
   reg              faultHold;
   reg  [7:0]       next_rdata;
   reg  [NFLAG-1:0] next_latched;
   reg              next_irq;
   reg              faultNow;
   wire [NFLAG-1:0] liveS;
   wire [NFLAG-1:0] faultS;
   wire [1:0]       ovlS;
   wire             timerActive;
   wire [1:0]       evtMode;
   wire [1:0]       pdSel;
   wire [NFLAG-1:0] unmaskedLatched;
   wire [NFLAG-1:0] unmaskedLive;
   wire [NFLAG-1:0] newEvent;
   wire [NFLAG-1:0] liveRise;
   wire             timerPeriodic;
   wire             timerShot;
   wire             wrIntCfg;
   wire             wrMuteCfg;
   wire             wrTuneCfg;
   wire             wrCh1Cfg;

   aft_sync3 #(.WIDTH(NFLAG)) liveSync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .din     (liveFlag),
      .dout    (liveS)
   );
   aft_sync3 #(.WIDTH(NFLAG)) faultSync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .din     (faultFlag),
      .dout    (faultS)
   );
   aft_sync3 #(.WIDTH(2)) ovlSync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .din     ({ch1Overload, ch2Overload}),
      .dout    (ovlS)
   );

   assign evtMode = intCfg[`AFT_EVT_HI:`AFT_EVT_LO];
   assign pdSel   = intCfg[`AFT_PD_HI:`AFT_PD_LO];
   assign unmaskedLatched = latched & ~flagMask;
   assign unmaskedLive    = liveS & ~flagMask;
   assign newEvent        = liveS & ~prevLive & ~flagMask;
   assign liveRise        = liveS & ~prevLive;
   assign timerPeriodic   = (evtMode == `AFT_EVT_PERIODIC)
                            && (|unmaskedLatched);
   assign timerShot       = (evtMode == `AFT_EVT_ONE_PULSE)
                            && (|newEvent);

   // status and unmapped addresses get no write strobe
   assign wrIntCfg  = regWrite && (regAddr == `AFT_ADDR_INT_CFG);
   assign wrMuteCfg = regWrite && (regAddr == `AFT_ADDR_MUTE_CFG);
   assign wrTuneCfg = regWrite && (regAddr == `AFT_ADDR_TUNE_CFG);
   assign wrCh1Cfg  = regWrite && (regAddr == `AFT_ADDR_CH1_CFG);

   aft_pulse_timer #(
      .PULSE_CYCLES  (PULSE_CYCLES),
      .PERIOD_CYCLES (PERIOD_CYCLES),
      .CW            (CW)
   ) irqTimer (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .periodic (timerPeriodic),
      .shot     (timerShot),
      .active   (timerActive)
   );

   // read mux, reserved bits masked to zero
   always @* begin
      case (regAddr)
         `AFT_ADDR_RATIO_HIGH: next_rdata = {2'h0, ratioHigh};
         `AFT_ADDR_RATIO_LOW:  next_rdata = ratioLow;
         `AFT_ADDR_INT_CFG:    next_rdata = intCfg;
         `AFT_ADDR_MUTE_CFG:   next_rdata = muteCfg & `AFT_MASK_MUTE_CFG;
         `AFT_ADDR_TUNE_CFG:   next_rdata = tuneCfg & `AFT_MASK_TUNE_CFG;
         `AFT_ADDR_CH1_CFG:    next_rdata = ch1Cfg & `AFT_MASK_CH1_CFG;
         default:              next_rdata = `AFT_RESET_BYTE;
      endcase
   end

   // rising live condition sets a latch; a set wins over a read clear
   always @* begin
      next_latched = latched;
      if (latchRead) begin
         if (intCfg[`AFT_BIT_CLR_POLICY]) begin
            next_latched = {NFLAG{1'b0}};
         end else begin
            next_latched = latched & liveS;
         end
      end
      next_latched = next_latched | liveRise;
   end

   always @* begin
      case (evtMode)
         `AFT_EVT_LATCHED:  next_irq = |unmaskedLatched;
         `AFT_EVT_LIVE:     next_irq = |unmaskedLive;
         `AFT_EVT_PERIODIC: next_irq = timerActive;
         default:           next_irq = timerActive;
      endcase
   end

   always @* begin
      case (pdSel)
         `AFT_PD_UNMASKED: faultNow = |(faultS & ~flagMask);
         `AFT_PD_ALL:      faultNow = |faultS;
         default:          faultNow = 1'b0;
      endcase
   end

   // both ratio halves taken together on ratioDone; no read snapshot, so a high then low read across a new result mixes two
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ratioHigh <= {`AFT_RATIO_HIGH_W{1'b0}};
         ratioLow  <= {`AFT_RATIO_LOW_W{1'b0}};
      end else if (ratioDone) begin
         ratioHigh <= ratioValue[`AFT_RATIO_LOW_W+:`AFT_RATIO_HIGH_W];
         ratioLow  <= ratioValue[`AFT_RATIO_LOW_W-1:0];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         intCfg  <= `AFT_RESET_BYTE;
         muteCfg <= `AFT_RESET_BYTE;
         tuneCfg <= `AFT_RESET_BYTE;
         ch1Cfg  <= `AFT_RESET_BYTE;
      end else begin
         if (wrIntCfg) begin
            intCfg <= regWdata;
         end
         if (wrMuteCfg) begin
            muteCfg <= regWdata & `AFT_MASK_MUTE_CFG;
         end
         if (wrTuneCfg) begin
            tuneCfg <= regWdata & `AFT_MASK_TUNE_CFG;
         end
         if (wrCh1Cfg) begin
            ch1Cfg <= regWdata & `AFT_MASK_CH1_CFG;
         end
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= `AFT_RESET_BYTE;
      end else if (regRead) begin
         regRdata <= next_rdata;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         latched  <= {NFLAG{1'b0}};
         prevLive <= {NFLAG{1'b0}};
      end else begin
         latched  <= next_latched;
         prevLive <= liveS;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         latchedView <= {NFLAG{1'b0}};
      end else if (intCfg[`AFT_BIT_READ_FILT]) begin
         latchedView <= latched & ~flagMask;
      end else begin
         latchedView <= latched;
      end
   end

   // manual recovery keeps channels down until the selector is set to none
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         faultHold <= 1'b0;
      end else if (faultNow) begin
         faultHold <= 1'b1;
      end else if (!intCfg[`AFT_BIT_RECOVERY]) begin
         faultHold <= 1'b0;
      end else if (pdSel == `AFT_PD_NONE) begin
         faultHold <= 1'b0;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irqOut <= 1'b1;
      end else begin
         irqOut <= intCfg[`AFT_BIT_POL] ? next_irq : ~next_irq;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         channelPowerDown <= 1'b0;
      end else begin
         channelPowerDown <= faultNow | faultHold;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ch1Mute <= 1'b0;
      end else begin
         ch1Mute <= muteCfg[`AFT_BIT_CH1_MUTE] & ovlS[1];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ch2Mute <= 1'b0;
      end else begin
         ch2Mute <= muteCfg[`AFT_BIT_CH2_MUTE] & ovlS[0];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         modulatorClockHalve <= 1'b0;
      end else begin
         modulatorClockHalve <= tuneCfg[`AFT_BIT_MOD_HALVE];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         combFilterOrder <= 1'b0;
      end else begin
         combFilterOrder <= tuneCfg[`AFT_BIT_COMB_ORDER];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         firStageSkip <= 1'b0;
      end else begin
         firStageSkip <= tuneCfg[`AFT_BIT_FIR_SKIP];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         elementMatchingRateDouble <= 1'b0;
      end else begin
         elementMatchingRateDouble <= tuneCfg[`AFT_BIT_DEM_DOUBLE];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lowPowerFilterSel <= 1'b0;
      end else begin
         lowPowerFilterSel <= tuneCfg[`AFT_BIT_LOW_PWR];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ch1InputSource <= 2'h0;
         ch1Coupling    <= 2'h0;
      end else begin
         ch1InputSource <= ch1Cfg[`AFT_CH1_SRC_HI:`AFT_CH1_SRC_LO];
         ch1Coupling    <= ch1Cfg[`AFT_CH1_CPL_HI:`AFT_CH1_CPL_LO];
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ch1FullScale <= 1'b0;
         ch1Bandwidth <= 1'b0;
      end else begin
         ch1FullScale <= ch1Cfg[`AFT_BIT_CH1_FS];
         ch1Bandwidth <= ch1Cfg[`AFT_BIT_CH1_BW];
      end
   end
endmodule

/* File: logic/aft_sync3.v */
// three-stage synchroniser; change taken once stages two and three agree
`timescale 1ns/1ps
module aft_sync3 #(
   parameter WIDTH = 1
) (
   input  wire             mclk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         dout   <= {WIDTH{1'b0}};
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               dout[i] <= stage3[i];
            end
         end
      end
   end
endmodule

/* File: pkg/aft_defines.vh */
// register map, field positions and timing constants of the tune block
`ifndef AFT_DEFINES_VH
`define AFT_DEFINES_VH
`define AFT_ADDR_RATIO_HIGH   8'h40
`define AFT_ADDR_RATIO_LOW    8'h41
`define AFT_ADDR_INT_CFG      8'h42
`define AFT_ADDR_MUTE_CFG     8'h4B
`define AFT_ADDR_TUNE_CFG     8'h4E
`define AFT_ADDR_CH1_CFG      8'h50
`define AFT_RESET_BYTE        8'h00
`define AFT_MASK_INT_CFG      8'hFF
`define AFT_MASK_MUTE_CFG     8'h18
`define AFT_MASK_TUNE_CFG     8'hF4
`define AFT_MASK_CH1_CFG      8'hCF
`define AFT_RATIO_HIGH_W      6
`define AFT_RATIO_LOW_W       8
`define AFT_BIT_POL           7
`define AFT_EVT_HI            6
`define AFT_EVT_LO            5
`define AFT_PD_HI             4
`define AFT_PD_LO             3
`define AFT_BIT_READ_FILT     2
`define AFT_BIT_RECOVERY      1
`define AFT_BIT_CLR_POLICY    0
`define AFT_BIT_CH1_MUTE      4
`define AFT_BIT_CH2_MUTE      3
`define AFT_BIT_MOD_HALVE     7
`define AFT_BIT_COMB_ORDER    6
`define AFT_BIT_FIR_SKIP      5
`define AFT_BIT_DEM_DOUBLE    4
`define AFT_BIT_LOW_PWR       2
`define AFT_CH1_SRC_HI        7
`define AFT_CH1_SRC_LO        6
`define AFT_CH1_CPL_HI        3
`define AFT_CH1_CPL_LO        2
`define AFT_BIT_CH1_FS        1
`define AFT_BIT_CH1_BW        0
`define AFT_EVT_LATCHED       2'h0
`define AFT_EVT_LIVE          2'h1
`define AFT_EVT_PERIODIC      2'h2
`define AFT_EVT_ONE_PULSE     2'h3
`define AFT_PD_NONE           2'h0
`define AFT_PD_UNMASKED       2'h1
`define AFT_PD_ALL            2'h2
`define AFT_PULSE_MS          2
`define AFT_PERIOD_MS         4
`define AFT_CLK_KHZ           100000
`endif

/* File: testbench/aft_regs_chk.sv */
// checker for register access, interrupt pin, power-down and mute
`timescale 1ns/1ps
module aft_regs_chk #(
   parameter NFLAG = 8
) (
   input wire             mclk,
   input wire             reset_n,
   input wire             regWrite,
   input wire             regRead,
   input wire [7:0]       regAddr,
   input wire [7:0]       regWdata,
   input wire [7:0]       regRdata,
   input wire [NFLAG-1:0] liveFlag,
   input wire [NFLAG-1:0] flagMask,
   input wire [NFLAG-1:0] latchedView,
   input wire             ch1Overload,
   input wire             ch2Overload,
   input wire             irqOut,
   input wire             channelPowerDown,
   input wire             ch1Mute,
   input wire             ch2Mute,
   input wire             modulatorClockHalve,
   input wire             combFilterOrder,
   input wire             firStageSkip,
   input wire             elementMatchingRateDouble,
   input wire             lowPowerFilterSel
);
   reg  [7:0] intCfg;
   reg  [7:0] muteCfg;
   wire       w4e  = regWrite && regAddr == 8'h4E;
   wire       actL = |(latchedView & ~flagMask);
   wire       actV = |(liveFlag & ~flagMask);
   wire [4:0] tune = {modulatorClockHalve, combFilterOrder, firStageSkip,
                      elementMatchingRateDouble, lowPowerFilterSel};
   // shadow copies of the interrupt and mute configuration writes
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         intCfg  <= 8'h00;
         muteCfg <= 8'h00;
      end else begin
         if (regWrite && regAddr == 8'h42)
            intCfg <= regWdata;
         if (regWrite && regAddr == 8'h4B)
            muteCfg <= regWdata;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   tune_copy_a: assert property (
      w4e ##1 !w4e |-> ##1 tune ==
      {$past(regWdata[7:4], 2), $past(regWdata[2], 2)})
      else $error("tune outputs differ from written bits");
   unmapped_zero_a: assert property (
      regRead && regAddr == 8'h43 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (
      regRead && regAddr == 8'h4B |=> (regRdata & 8'hE7) == 8'h00)
      else $error("reserved mute bits read nonzero");
   irq_latched_a: assert property (
      (intCfg[6:5] == 2'h0 && $stable(intCfg) && $stable(latchedView)
      && $stable(flagMask)) [*4] |-> irqOut == !(actL ^ intCfg[7]))
      else $error("latched mode interrupt level wrong");
   irq_live_a: assert property (
      (intCfg[6:5] == 2'h1 && $stable(intCfg) && $stable(liveFlag)
      && $stable(flagMask)) [*8] |-> irqOut == !(actV ^ intCfg[7]))
      else $error("live mode interrupt level wrong");
   pd_none_a: assert property (
      (intCfg[4:3] == 2'h0 && $stable(intCfg)) [*4] |-> !channelPowerDown)
      else $error("power-down with selector at none");
   read_filter_a: assert property (
      (intCfg[2] && $stable(intCfg) && $stable(flagMask)) [*4]
      |-> (latchedView & flagMask) == 0)
      else $error("masked flag shown with filter set");
   mute_one_a: assert property (
      ($stable(muteCfg) && $stable(ch1Overload)) [*8]
      |-> ch1Mute == (muteCfg[4] & ch1Overload))
      else $error("channel 1 mute wrong");
   mute_two_a: assert property (
      ($stable(muteCfg) && $stable(ch2Overload)) [*8]
      |-> ch2Mute == (muteCfg[3] & ch2Overload))
      else $error("channel 2 mute wrong");
   shot_c: cover property (intCfg[6:5] == 2'h3 && $rose(irqOut));
   pd_c: cover property ($rose(channelPowerDown));
   mute_c: cover property ($rose(ch1Mute));
endmodule

/* File: testbench/aft_regs_tb.sv */
// self-checking bench for the tune block registers
`timescale 1ns/1ps
module aft_regs_tb;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic [13:0] ratioValue = 14'h0000;
   logic        ratioDone = 1'b0;
   logic [7:0]  liveFlag = 8'h00;
   logic [7:0]  flagMask = 8'h00;
   logic        latchRead = 1'b0;
   logic [7:0]  faultFlag = 8'h00;
   logic [1:0]  ovl = 2'b00;
   logic [7:0]  regRdata, latchedView, d;
   logic        irqOut, channelPowerDown;
   logic [1:0]  mute;
   logic [4:0]  tune;
   logic [5:0]  ch1Cfg;
   int          errors = 0;
   int          comparisons = 0;
   int          cnt;
   logic [7:0]  addrs [6] = '{8'h40, 8'h41, 8'h42, 8'h4B, 8'h4E, 8'h50};
   logic [7:0]  masks [6] = '{8'h00, 8'h00, 8'hFF, 8'h18, 8'hF4, 8'hCF};
   always #5 mclk = ~mclk;
   aft_regs #(.PULSE_CYCLES(20), .PERIOD_CYCLES(40)) dut (
      .mclk(mclk), .reset_n(reset_n), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .ratioValue(ratioValue), .ratioDone(ratioDone),
      .liveFlag(liveFlag), .flagMask(flagMask), .latchRead(latchRead),
      .latchedView(latchedView), .faultFlag(faultFlag),
      .ch1Overload(ovl[1]), .ch2Overload(ovl[0]), .irqOut(irqOut),
      .channelPowerDown(channelPowerDown), .ch1Mute(mute[1]),
      .ch2Mute(mute[0]), .modulatorClockHalve(tune[4]),
      .combFilterOrder(tune[3]), .firStageSkip(tune[2]),
      .elementMatchingRateDouble(tune[1]), .lowPowerFilterSel(tune[0]),
      .ch1InputSource(ch1Cfg[5:4]), .ch1Coupling(ch1Cfg[3:2]),
      .ch1FullScale(ch1Cfg[1]), .ch1Bandwidth(ch1Cfg[0]));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string n, input logic [13:0] e, g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = v;
      cyc(1);
      regWrite = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      regRead = 1'b1;
      regAddr = a;
      cyc(1);
      regRead = 1'b0;
      v = regRdata;
      cyc(1);
   endtask
   task automatic lr;
      latchRead = 1'b1;
      cyc(1);
      latchRead = 1'b0;
      cyc(4);
   endtask
   task automatic hi(input int n);
      cnt = 0;
      repeat (n) begin
         cyc(1);
         cnt += irqOut;
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      stop_test;
   end
   initial begin
      cyc(6);
      reset_n = 1'b1;
      cyc(1);
      for (int i = 0; i < 6; i++) begin
         rd(addrs[i], d);
         chk("reset value", 8'h00, d);
      end
      rd(8'h43, d);
      chk("unmapped", 8'h00, d);
      for (int i = 0; i < 6; i++) begin
         wr(addrs[i], 8'hFF);
         rd(addrs[i], d);
         chk("write mask", masks[i], d);
      end
      chk("ch1 fields", 6'h3F, ch1Cfg);
      chk("tune all", 5'h1F, tune);
      for (int i = 0; i < 6; i++)
         wr(addrs[i], 8'h00);
      wr(8'h4E, 8'h54);
      chk("tune mix", 5'h0B, tune);
      $display("test registers done");
      ratioValue = 14'h2A5C;
      ratioDone = 1'b1;
      cyc(1);
      ratioDone = 1'b0;
      ratioValue = 14'h15A3;
      rd(8'h40, d);
      chk("ratio high", 8'h2A, d);
      rd(8'h41, d);
      chk("ratio low", 8'h5C, d);
      $display("test ratio done");
      liveFlag = 8'h01;
      cyc(8);
      chk("irq low", 1'b0, irqOut);
      liveFlag = 8'h00;
      cyc(8);
      chk("irq held", 1'b0, irqOut);
      lr;
      chk("cleared", 8'h00, latchedView);
      chk("irq idle", 1'b1, irqOut);
      liveFlag = 8'h01;
      cyc(8);
      lr;
      chk("kept live", 8'h01, latchedView);
      flagMask = 8'h01;
      wr(8'h42, 8'h04);
      cyc(4);
      chk("filtered", 8'h00, latchedView);
      wr(8'h42, 8'h00);
      cyc(4);
      chk("unfiltered", 8'h01, latchedView);
      wr(8'h42, 8'h01);
      lr;
      chk("clear always", 8'h00, latchedView);
      wr(8'h42, 8'hA0);
      liveFlag = 8'h03;
      cyc(8);
      chk("live high", 1'b1, irqOut);
      liveFlag = 8'h01;
      cyc(8);
      chk("live gone", 1'b0, irqOut);
      flagMask = 8'h00;
      liveFlag = 8'h00;
      cyc(8);
      lr;
      wr(8'h42, 8'hE0);
      liveFlag = 8'h04;
      hi(60);
      chk("one pulse", 1'b1, cnt >= 19 && cnt <= 21);
      wr(8'h42, 8'hC0);
      hi(80);
      chk("periodic", 1'b1, cnt >= 38 && cnt <= 42);
      liveFlag = 8'h00;
      wr(8'h42, 8'h00);
      cyc(8);
      lr;
      $display("test interrupt done");
      wr(8'h42, 8'h10);
      faultFlag = 8'h01;
      cyc(8);
      chk("pd all", 1'b1, channelPowerDown);
      faultFlag = 8'h00;
      cyc(8);
      chk("auto up", 1'b0, channelPowerDown);
      wr(8'h42, 8'h12);
      faultFlag = 8'h01;
      cyc(8);
      faultFlag = 8'h00;
      cyc(8);
      chk("manual", 1'b1, channelPowerDown);
      wr(8'h42, 8'h08);
      flagMask = 8'h01;
      faultFlag = 8'h01;
      cyc(8);
      chk("masked fault", 1'b0, channelPowerDown);
      flagMask = 8'h00;
      cyc(8);
      chk("unmasked", 1'b1, channelPowerDown);
      faultFlag = 8'h00;
      wr(8'h42, 8'h00);
      $display("test power-down done");
      wr(8'h4B, 8'h10);
      ovl = 2'b11;
      cyc(8);
      chk("mute ch1", 2'b10, mute);
      wr(8'h4B, 8'h08);
      cyc(8);
      chk("mute ch2", 2'b01, mute);
      ovl = 2'b00;
      cyc(8);
      chk("no mute", 2'b00, mute);
      $display("test mute done");
      stop_test;
   end
endmodule
bind aft_regs aft_regs_chk #(.NFLAG(NFLAG)) chk (
   .mclk(mclk), .reset_n(reset_n), .regWrite(regWrite),
   .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .liveFlag(liveFlag), .flagMask(flagMask),
   .latchedView(latchedView), .ch1Overload(ch1Overload),
   .ch2Overload(ch2Overload), .irqOut(irqOut),
   .channelPowerDown(channelPowerDown), .ch1Mute(ch1Mute),
   .ch2Mute(ch2Mute), .modulatorClockHalve(modulatorClockHalve),
   .combFilterOrder(combFilterOrder), .firStageSkip(firStageSkip),
   .elementMatchingRateDouble(elementMatchingRateDouble),
   .lowPowerFilterSel(lowPowerFilterSel));
